//--- core/adcc_pkg.sv
// Purpose: Constants and types for the converter control register block
// Assumes: 8-bit special-function register bus, one 125 MHz clock
package adcc_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] ADCC_CTRL_ADDR  = 8'hE8;
  localparam logic [7:0] ADCC_CTRL_RESET = 8'h00;
  localparam int         ADCC_B_ENABLE   = 7;
  localparam int         ADCC_B_BURST    = 6;
  localparam int         ADCC_B_DONE     = 5;
  localparam int         ADCC_B_BUSY     = 4;
  localparam int         ADCC_B_WINDOW   = 3;
  localparam int         ADCC_B_LJUST    = 2;
  localparam int         ADCC_B_SRC_HI   = 1;
  localparam int         ADCC_B_SRC_LO   = 0;
  localparam logic [1:0] ADCC_SRC_SW     = 2'h0;

  // ********************************************************
  // Repeat counts
  // ********************************************************
  localparam logic [4:0] ADCC_RPT_1  = 5'h01;
  localparam logic [4:0] ADCC_RPT_4  = 5'h04;
  localparam logic [4:0] ADCC_RPT_8  = 5'h08;
  localparam logic [4:0] ADCC_RPT_16 = 5'h10;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONV,
    ADCC_WAIT
  } adcc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
  } adcc_bus_t;

  typedef struct packed {
    logic       powered;
    logic       start;
  } adcc_conv_t;

endpackage

//--- core/adcc_seq.sv
// Purpose: Conversion sequencer for the repeat count and completion
// Assumes: Converter gives a one-cycle done per single conversion
// Notes:   Starts are ignored while a sequence runs
`timescale 1ns/1ps
`default_nettype none
module adcc_seq (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_go,
  input  wire logic [1:0] i_repeat_count,
  input  wire logic       i_conv_done,
  output logic            o_busy,
  output logic            o_finish,
  output logic            o_conv_start
);
  import adcc_pkg::*;

  typedef struct packed {
    adcc_state_t state;
    logic [4:0]  remain;
    logic        busy;
    logic        finish;
    logic        start;
  } adcc_seq_t;

  adcc_seq_t s_r;
  adcc_seq_t s_nxt;
  logic [4:0] total;

  always_comb begin
    case (i_repeat_count)
      2'h0:    total = ADCC_RPT_1;
      2'h1:    total = ADCC_RPT_4;
      2'h2:    total = ADCC_RPT_8;
      default: total = ADCC_RPT_16;
    endcase
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.finish = 1'b0;
    s_nxt.start  = 1'b0;
    case (s_r.state)
      ADCC_IDLE: begin
        if (i_go) begin
          s_nxt.state  = ADCC_CONV;
          s_nxt.remain = total;
          s_nxt.busy   = 1'b1;
          s_nxt.start  = 1'b1;
        end
      end
      ADCC_CONV: begin
        if (i_conv_done) begin
          if (s_r.remain == ADCC_RPT_1) begin
            s_nxt.state  = ADCC_IDLE;
            s_nxt.busy   = 1'b0;
            s_nxt.finish = 1'b1;
          end else begin
            s_nxt.remain = s_r.remain - ADCC_RPT_1;
            s_nxt.state  = ADCC_WAIT;
          end
        end
      end
      default: begin
        // One idle cycle so the converter sees a fresh start edge
        s_nxt.state = ADCC_CONV;
        s_nxt.start = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy       = s_r.busy;
  assign o_finish     = s_r.finish;
  assign o_conv_start = s_r.start;
endmodule
`default_nettype wire

//--- core/adcc_top.sv
// Purpose: Converter control register with start, busy and flags
// Assumes: Byte and single-bit writes arrive on the register bus
// Notes:   Analog core, window limits and clock divider live outside
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire adcc_pkg::adcc_bus_t i_bus,
  input  wire logic [1:0]        i_repeat_count,
  input  wire logic [1:0]        i_trig,
  input  wire logic              i_conv_done,
  input  wire logic              i_window_match,
  output logic [7:0]             o_rdata,
  output logic                   o_conv_start,
  output logic                   o_powered,
  output logic                   o_left_justify,
  output logic                   o_burst_enable,
  output logic [1:0]             o_start_source_sel
);
  import adcc_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       powered;
    logic       go;
    logic       burst_hold;
  } adcc_top_t;

  adcc_top_t s_r;
  adcc_top_t s_nxt;
  logic      busy;
  logic      finish;
  logic      seq_start;
  logic      sel;
  logic [7:0] wr_val;
  logic [7:0] wr_mask;

  adcc_seq u_seq (
    .i_core_clk     (i_core_clk),
    .i_reset_n      (i_reset_n),
    .i_go           (s_r.go),
    .i_repeat_count (i_repeat_count),
    .i_conv_done    (i_conv_done),
    .o_busy         (busy),
    .o_finish       (finish),
    .o_conv_start   (seq_start)
  );

  // ********************************************************
  // Bus decode
  // ********************************************************
  always_comb begin
    sel     = (i_bus.addr == ADCC_CTRL_ADDR);
    wr_val  = i_bus.wdata;
    wr_mask = 8'hFF;
    if (i_bus.bit_wr) begin
      // Bit access touches only the addressed bit
      wr_mask = 8'h01 << i_bus.bit_idx;
      wr_val  = {8{i_bus.bit_val}};
    end
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    s_nxt    = s_r;
    s_nxt.go = 1'b0;
    if (sel && (i_bus.wr || i_bus.bit_wr)) begin
      s_nxt.ctrl = (s_r.ctrl & ~wr_mask) | (wr_val & wr_mask);
      // Busy is owned by the sequencer; a written 1 only starts
      s_nxt.ctrl[ADCC_B_BUSY] = s_r.ctrl[ADCC_B_BUSY];
      // Burst with enable clear still takes starts and wakes per start
      if (wr_mask[ADCC_B_BUSY] && wr_val[ADCC_B_BUSY] &&
          s_r.ctrl[ADCC_B_SRC_HI:ADCC_B_SRC_LO] == ADCC_SRC_SW &&
          (s_r.ctrl[ADCC_B_ENABLE] || s_r.ctrl[ADCC_B_BURST])) begin
        s_nxt.go = 1'b1;
      end
    end
    if ((s_r.ctrl[ADCC_B_ENABLE] || s_r.ctrl[ADCC_B_BURST]) &&
        s_r.ctrl[ADCC_B_SRC_HI:ADCC_B_SRC_LO] != ADCC_SRC_SW &&
        i_trig[0]) begin
      s_nxt.go = 1'b1;
    end
    // Hardware set wins over a same-cycle software clear
    if (finish) begin
      s_nxt.ctrl[ADCC_B_DONE] = 1'b1;
    end
    if (i_window_match) begin
      s_nxt.ctrl[ADCC_B_WINDOW] = 1'b1;
    end
    // Go is in flight to the sequencer for a cycle; cover it, no dip
    s_nxt.ctrl[ADCC_B_BUSY] = busy | s_r.go | s_nxt.go;
    // Power: enable holds it on; burst with enable clear wakes per start
    if (s_nxt.ctrl[ADCC_B_ENABLE]) begin
      s_nxt.powered = 1'b1;
    end else if (s_nxt.ctrl[ADCC_B_BURST]) begin
      s_nxt.burst_hold = s_nxt.ctrl[ADCC_B_BUSY];
      s_nxt.powered    = s_nxt.burst_hold;
    end else begin
      s_nxt.powered    = 1'b0;
      s_nxt.burst_hold = 1'b0;
    end
    s_nxt.rdata = s_nxt.ctrl;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign o_rdata            = s_r.rdata;
  assign o_conv_start       = seq_start;
  assign o_powered          = s_r.powered;
  assign o_left_justify     = s_r.ctrl[ADCC_B_LJUST];
  assign o_burst_enable     = s_r.ctrl[ADCC_B_BURST];
  assign o_start_source_sel = s_r.ctrl[ADCC_B_SRC_HI:ADCC_B_SRC_LO];
endmodule
`default_nettype wire

//--- test/adcc_props.sv
// Purpose: Port assertions for the converter control register
// Assumes: o_rdata shows a taken write one cycle later
// Notes:   Bound into adcc_top below
`timescale 1ns/1ps
`default_nettype none
module adcc_props (
  input wire logic                i_core_clk,
  input wire logic                i_reset_n,
  input wire adcc_pkg::adcc_bus_t i_bus,
  input wire logic [1:0]          i_repeat_count,
  input wire logic [1:0]          i_trig,
  input wire logic                i_conv_done,
  input wire logic                i_window_match,
  input wire logic [7:0]          o_rdata,
  input wire logic                o_conv_start,
  input wire logic                o_powered,
  input wire logic                o_left_justify,
  input wire logic                o_burst_enable,
  input wire logic [1:0]          o_start_source_sel
);
  import adcc_pkg::*;
  logic hit;
  logic any_wr;
  assign hit    = i_bus.addr == ADCC_CTRL_ADDR;
  assign any_wr = hit && (i_bus.wr || i_bus.bit_wr);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ********
  // Checks
  // ********
  AST_BYTE_WR: assert property (
    hit && i_bus.wr && !i_bus.bit_wr |=> {o_rdata[7:6], o_rdata[2:0]}
    == $past({i_bus.wdata[7:6], i_bus.wdata[2:0]})) else $error("byte lost");
  AST_BIT_WR: assert property (
    hit && i_bus.bit_wr && !i_bus.wr && i_bus.bit_idx == 3'h6
    |=> o_rdata[6] == $past(i_bus.bit_val)) else $error("bit write lost");
  AST_DONE_HOLD: assert property (
    o_rdata[5] && !any_wr |=> o_rdata[5]) else $error("done flag lost");
  AST_WIN_HOLD: assert property (
    o_rdata[3] && !any_wr |=> o_rdata[3]) else $error("window flag lost");
  AST_WIN_SET: assert property (
    i_window_match |=> o_rdata[3]) else $error("window flag not set");
  AST_SW_START: assert property (
    hit && i_bus.wr && i_bus.wdata[7] && i_bus.wdata[4] && o_rdata[7]
    && i_bus.wdata[1:0] == 2'h0 && o_rdata[4:0] == 5'h00
    |=> o_rdata[4] ##1 o_conv_start) else $error("start not taken");
  AST_SRC_REFUSE: assert property (
    hit && i_bus.wr && i_bus.wdata[4] && i_bus.wdata[1:0] != 2'h0
    && o_rdata[1:0] != 2'h0 && !o_rdata[4] && !i_trig[0]
    |=> !o_rdata[4]) else $error("start from wrong source");
  AST_FALL_DONE: assert property (
    $fell(o_rdata[4]) |-> o_rdata[5]) else $error("busy fell, no done");
  AST_START_BUSY: assert property (
    o_conv_start |-> o_rdata[4]) else $error("start while not busy");
  AST_POWER: assert property (
    o_rdata[7] |-> o_powered) else $error("enabled but unpowered");
  AST_BURST_WAKE: assert property (
    !o_rdata[7] && o_rdata[6] |-> o_powered == o_rdata[4])
    else $error("burst power not per start");
  AST_OFF: assert property (
    !o_rdata[7] && !o_rdata[6] |-> !o_powered) else $error("off but powered");
endmodule
bind adcc_top adcc_props u_props (.i_core_clk, .i_reset_n, .i_bus,
  .i_repeat_count, .i_trig, .i_conv_done, .i_window_match, .o_rdata,
  .o_conv_start, .o_powered, .o_left_justify, .o_burst_enable,
  .o_start_source_sel);
`default_nettype wire

//--- test/test_adcc_top.sv
// Purpose: Self-checking bench for the converter control register
// Assumes: Flags and busy show in o_rdata within three cycles
// Notes:   Software starts, one trigger pulse and a reset while idle
`timescale 1ns/1ps
`default_nettype none
module test_adcc_top;
  import adcc_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       done  = 1'b0;
  logic       win   = 1'b0;
  logic [1:0] rpt   = 2'h0;
  logic [1:0] trig  = 2'h0;
  adcc_bus_t  bus   = '0;
  logic [7:0] rdata;
  logic       start;
  logic       pwr;
  logic       ljust;
  logic       burst;
  logic [1:0] src;
  logic [4:0] eo;
  logic [7:0] q[$];
  logic [7:0] d;
  logic [7:0] e;
  int         n;
  int         error_cnt   = 0;
  int         check_count = 0;
  adcc_top dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_bus(bus),
    .i_repeat_count(rpt), .i_trig(trig), .i_conv_done(done),
    .i_window_match(win), .o_rdata(rdata), .o_conv_start(start),
    .o_powered(pwr), .o_left_justify(ljust), .o_burst_enable(burst),
    .o_start_source_sel(src));
  initial forever #4 clk = ~clk;
  // ********
  // Result watcher
  // ********
  always @(negedge clk) if (q.size() > 0) begin
    e = q.pop_front();
    check_count++;
    if (rdata !== e) begin
      $display("BAD o_rdata exp %h got %h", e, rdata);
      error_cnt++;
    end
    eo = {e[7] | (e[6] & e[4]), e[2], e[6], e[1:0]};
    check_count++;
    if ({pwr, ljust, burst, src} !== eo) begin
      $display("BAD outputs exp %b got %b", eo, {pwr, ljust, burst, src});
      error_cnt++;
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Strobe dropped a full cycle early so back to back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus.addr <= a; bus.wdata <= v; bus.wr <= 1'b1;
    @(posedge clk); bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bw(input logic [2:0] i, input logic v);
    bus.addr <= ADCC_CTRL_ADDR; bus.bit_idx <= i; bus.bit_val <= v;
    bus.bit_wr <= 1'b1;
    @(posedge clk); bus.bit_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conv(input int r);
    for (int i = 0; i < r; i++) begin
      for (n = 0; n < 40; n++) begin
        @(negedge clk);
        if (start === 1'b1) break;
      end
      if (n == 40) begin error_cnt++; report_and_stop(); end
      @(posedge clk); done <= 1'b1;
      @(posedge clk); done <= 1'b0;
    end
  endtask
  initial begin
    void'($urandom(32'h1b9e9bf2));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    q.push_back(ADCC_CTRL_RESET);
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom) & 8'hC7;
      wr(ADCC_CTRL_ADDR, d);
      wr(8'hE9 + 8'(k), 8'hFF);
      q.push_back(d);
    end
    wr(ADCC_CTRL_ADDR, 8'h81);
    wr(ADCC_CTRL_ADDR, 8'h91);
    q.push_back(8'h81);
    bw(3'h0, 1'b0);
    q.push_back(8'h80);
    win <= 1'b1; @(posedge clk); win <= 1'b0;
    repeat (3) @(posedge clk);
    q.push_back(8'h88);
    wr(ADCC_CTRL_ADDR, 8'h80);
    q.push_back(8'h80);
    for (int c = 0; c < 4; c++) begin
      rpt <= 2'(c);
      wr(ADCC_CTRL_ADDR, 8'h90);
      q.push_back(8'h90);
      conv(c == 0 ? 1 : 2 << c);
      repeat (3) @(posedge clk);
      q.push_back(8'hA0);
      bw(3'h5, 1'b0);
      q.push_back(8'h80);
    end
    rpt <= 2'h0;
    wr(ADCC_CTRL_ADDR, 8'h81);
    q.push_back(8'h81);
    trig <= {1'($urandom), 1'b1};
    @(posedge clk);
    trig <= 2'h0;
    q.push_back(8'h91);
    conv(1);
    repeat (3) @(posedge clk);
    q.push_back(8'hA1);
    bw(3'h5, 1'b0);
    q.push_back(8'h81);
    wr(ADCC_CTRL_ADDR, 8'h00);
    q.push_back(8'h00);
    bw(3'h6, 1'b1);
    q.push_back(8'h40);
    wr(ADCC_CTRL_ADDR, 8'h50);
    q.push_back(8'h50);
    conv(1);
    repeat (3) @(posedge clk);
    q.push_back(8'h60);
    bw(3'h5, 1'b0);
    q.push_back(8'h40);
    bw(3'h6, 1'b0);
    q.push_back(8'h00);
    wr(ADCC_CTRL_ADDR, 8'hC5);
    q.push_back(8'hC5);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    q.push_back(ADCC_CTRL_RESET);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
